// *** clock_config_map.vh ***
/*
 * Constants of the clock synthesizer configuration bank: register offsets,
 * field positions, reset values and store timing.
 * Assumes a 100 MHz system clock and inclusion by the store and bank modules.
 */
// What this block does
// - Output-one state field: 00 power down, 01 tri-state, 10 low, 11 enabled.
// - Ten-bit output-one divider, upper bits in 02h, lower at 03h; zero holds reset.
// - Eight select bits at 04h pick state A or B; only setting 1 defaults one.
// - Three control-select pins choose which of eight settings applies.
// - Load capacitor code bits 7:3 of 05h, default 0Ah, saturates at 20 pF.
// - Byte count in bits 7:1 of 06h, default 20h, limits next block read.
// - Store starts only on a zero-to-one change of the trigger bit.
// - Reads keep working while a store runs.
// - Store-in-progress status bit is readable for polling.
// - Lock bit takes effect only from the stored copy, refusing further stores.
// - Locked device still accepts volatile writes that act at once.
// - Shared pins become control selects only from the stored setting.
// - Grounded output supply forces serial pins and zero address bits.
// - Serial data travels most significant bit first.
// - Store status reads one while storing, zero once done.
// - Pin-function bit picks serial lines (0) or control selects (1).
// - Two register bits give the low slave address bits, default 01b.
`ifndef CLOCK_CONFIG_MAP_VH
`define CLOCK_CONFIG_MAP_VH

`define OFS_IDENT        8'h00
`define OFS_DEV_CTRL     8'h01
`define OFS_OUT1_CTRL    8'h02
`define OFS_DIV_LOW      8'h03
`define OFS_STATE_SEL    8'h04
`define OFS_XTAL_CAP     8'h05
`define OFS_COUNT_STORE  8'h06
`define OFS_LAST         8'h06

`define RST_DEV_CTRL     8'h01
`define RST_OUT1_CTRL    8'hb4
`define RST_DIV_LOW      8'h01
`define RST_STATE_SEL    8'h02
`define RST_XTAL_CAP     8'h50
`define RST_COUNT_STORE  8'h40

`define BIT_IN_PROGRESS  6
`define BIT_LOCK         5
`define BIT_PWDN         4
`define BIT_SRC_PLL      7
`define BIT_PIN_FN       6
`define BIT_TRIGGER      0

`define MASK_DEV_CTRL    8'h3f
`define MASK_XTAL_CAP    8'hf8
`define CAP_MAX_PF       5'h14

`define STATE_PWDN       2'h0
`define STATE_TRI        2'h1
`define STATE_LOW        2'h2
`define STATE_ON         2'h3

`define CLK_PERIOD_NS    10
`define STORE_TIME_NS    10000
`define STORE_CYCLES     (`STORE_TIME_NS / `CLK_PERIOD_NS)

`endif

// *** pin_filter.v ***
/*
 * Three-stage input synchroniser with agreement filter for a pin vector.
 * Assumes raw inputs asynchronous to clk.
 */
`timescale 1ns/100ps
`default_nettype none
module pin_filter #(
    parameter         W    = 4,
    parameter [W-1:0] INIT = {W{1'b1}}
)(
    // Clock and reset
    input  wire         clk,
    input  wire         nrst,
    // Pins
    input  wire [W-1:0] raw,
    output reg  [W-1:0] clean
);
    reg [W-1:0] s1;
    reg [W-1:0] s2;
    reg [W-1:0] s3;

    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s1    <= INIT;
            s2    <= INIT;
            s3    <= INIT;
            clean <= INIT;
        end
        else
        begin
            s1    <= raw;
            s2    <= s1;
            s3    <= s2;
            // Change accepted once stages two and three agree
            clean <= (s2 & s3) | (clean & (s2 ^ s3));
        end
    end
endmodule // pin_filter
`default_nettype wire

// *** nvm_store.v ***
/*
 * Nonvolatile copy of the configuration bytes with a timed store cycle.
 * Assumes start is a one-cycle pulse and the snapshot is stable with it.
 */
`timescale 1ns/100ps
`default_nettype none
`include "clock_config_map.vh"
module nvm_store #(
    parameter            BYTES    = 6,
    parameter            CYCLES   = `STORE_CYCLES,
    parameter [8*BYTES-1:0] CONTENT = 48'h0
)(
    // Clock and reset
    input  wire                 clk,
    input  wire                 nrst,
    // Store request
    input  wire                 start,
    input  wire [8*BYTES-1:0]   snapshot,
    // Stored content and status
    output wire [8*BYTES-1:0]   stored,
    output reg                  busy
);
    reg [7:0]  mem [0:BYTES-1];
    reg [15:0] timer;
    integer    i;

    genvar g;
    generate
        for (g = 0; g < BYTES; g = g + 1)
        begin : rd
            assign stored[8*g+7:8*g] = mem[g];
        end
    endgenerate

    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            for (i = 0; i < BYTES; i = i + 1)
                mem[i] <= CONTENT[8*i +: 8];
            busy  <= 1'b0;
            timer <= 16'h0000;
        end
        else if (start && !busy)
        begin
            for (i = 0; i < BYTES; i = i + 1)
                mem[i] <= snapshot[8*i +: 8];
            busy  <= 1'b1;
            timer <= CYCLES[15:0];
        end
        else if (busy)
        begin
            timer <= timer - 16'h0001;
            if (timer == 16'h0001)
                busy <= 1'b0;
        end
    end
endmodule // nvm_store
`default_nettype wire

// *** clock_config_bank.v ***
/*
 * Generic configuration register bank with its two-wire serial slave,
 * output-one state selection and nonvolatile store sequencing.
 * Assumes a 100 MHz clk, a host on the shared serial pins and pulled-up SDA.
 */
`timescale 1ns/100ps
`default_nettype none
`include "clock_config_map.vh"
module clock_config_bank #(
    parameter [7:0] IDENT_BYTE  = 8'h5a,   // Arbitrary identity value
    parameter [4:0] ADDR_HIGH   = 5'h0c,
    parameter       STORE_CYCLE = `STORE_CYCLES
)(
    // Clock and reset
    input  wire       clk,
    input  wire       nrst,
    // Control and shared pins
    input  wire       ctrl_select_0,
    input  wire       scl_pin,
    input  wire       sda_pin_in,
    output wire       sda_pin_out,
    output wire       sda_pin_oe_n,
    input  wire       output_supply,
    // Output one control
    output reg        out1_power_down,
    output reg        out1_tristate,
    output reg        out1_drive_low,
    output reg        out1_enable,
    output reg  [9:0] out1_divider,
    output reg        out1_divider_reset,
    output reg        out1_source_pll,
    // Device control
    output reg  [4:0] xtal_load_pf,
    output reg  [1:0] input_clock_select,
    output reg  [1:0] slave_address_low,
    output wire       nvm_store_in_progress,
    output reg        serial_pins_active
);
    localparam S_IDLE  = 4'h0;
    localparam S_ADDR  = 4'h1;
    localparam S_ACK_A = 4'h2;
    localparam S_CMD   = 4'h3;
    localparam S_ACK_C = 4'h4;
    localparam S_WDATA = 4'h5;
    localparam S_ACK_W = 4'h6;
    localparam S_RDATA = 4'h7;
    localparam S_RACK  = 4'h8;
    localparam S_NEXT  = 4'h9;

    // Volatile registers
    reg  [7:0]  dev_ctrl;
    reg  [7:0]  out1_ctrl;
    reg  [7:0]  div_low;
    reg  [7:0]  state_sel;
    reg  [7:0]  xtal_cap;
    reg  [7:0]  count_store;
    reg         boot;
    // Serial slave
    reg  [3:0]  state;
    reg  [3:0]  bitcnt;
    reg  [7:0]  shift;
    reg  [7:0]  tx;
    reg  [7:0]  ptr;
    reg  [6:0]  left;
    reg         drive_low;
    reg         scl_d;
    reg         sda_d;
    reg         wr_en;
    reg  [7:0]  wr_addr;
    reg  [7:0]  wr_data;
    // Filtered pins and nvm
    wire [3:0]  pins;
    wire [47:0] stored;
    wire        busy;
    wire        store_start;
    wire        locked;
    wire        grounded;
    wire        serial_on;
    wire [2:0]  setting;
    wire [1:0]  state_now;
    wire [7:0]  rd_data;
    wire        scl_f;
    wire        sda_f;
    wire        scl_rise;
    wire        scl_fall;
    wire        start_cond;
    wire        stop_cond;
    wire        addr_hit;

    function [7:0] read_reg;
        input [7:0] ofs;
        begin
            if (ofs == `OFS_IDENT)
                read_reg = IDENT_BYTE;
            else if (ofs == `OFS_DEV_CTRL)
                read_reg = {1'b0, busy, dev_ctrl[5:0]};
            else if (ofs == `OFS_OUT1_CTRL)
                read_reg = out1_ctrl;
            else if (ofs == `OFS_DIV_LOW)
                read_reg = div_low;
            else if (ofs == `OFS_STATE_SEL)
                read_reg = state_sel;
            else if (ofs == `OFS_XTAL_CAP)
                read_reg = xtal_cap;
            else if (ofs == `OFS_COUNT_STORE)
                read_reg = count_store;
            else
                read_reg = 8'h00;
        end
    endfunction

    pin_filter #(
        .W    (4),
        .INIT (4'hf)
    ) u_filter (
        .clk   (clk),
        .nrst  (nrst),
        .raw   ({output_supply, ctrl_select_0, scl_pin, sda_pin_in}),
        .clean (pins)
    );

    nvm_store #(
        .BYTES   (6),
        .CYCLES  (STORE_CYCLE),
        .CONTENT ({`RST_COUNT_STORE, `RST_XTAL_CAP, `RST_STATE_SEL,
                   `RST_DIV_LOW, `RST_OUT1_CTRL, `RST_DEV_CTRL})
    ) u_nvm (
        .clk      (clk),
        .nrst     (nrst),
        .start    (store_start),
        .snapshot ({count_store, xtal_cap, state_sel, div_low, out1_ctrl, dev_ctrl}),
        .stored   (stored),
        .busy     (busy)
    );

    assign nvm_store_in_progress = busy;
    assign locked    = stored[`BIT_LOCK];
    assign grounded  = ~pins[3];
    assign serial_on = ~stored[8 + `BIT_PIN_FN] | grounded;
    assign scl_f     = pins[1] | ~serial_on;
    assign sda_f     = pins[0] | ~serial_on;
    assign scl_rise  = scl_f & ~scl_d;
    assign scl_fall  = ~scl_f & scl_d;
    assign start_cond = scl_f & scl_d & sda_d & ~sda_f;
    assign stop_cond  = scl_f & scl_d & ~sda_d & sda_f;
    assign addr_hit  = (shift[7:1] == {ADDR_HIGH, slave_address_low});
    assign rd_data   = read_reg(ptr);
    assign sda_pin_out  = 1'b0;
    assign sda_pin_oe_n = ~drive_low;

    // Shared pins count as control selects only outside serial use; ctrl_select_0 always counts
    assign setting   = {serial_on ? 1'b0 : pins[1],
                        serial_on ? 1'b0 : pins[0], pins[2]};
    assign state_now = state_sel[setting] ? out1_ctrl[5:4] : out1_ctrl[3:2];

    // Store starts on a zero-to-one write of the trigger bit only
    assign store_start = wr_en && (wr_addr == `OFS_COUNT_STORE) && !busy && !locked
                         && wr_data[`BIT_TRIGGER] && !count_store[`BIT_TRIGGER];

    // Serial slave
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state     <= S_IDLE;
            bitcnt    <= 4'h0;
            shift     <= 8'h00;
            tx        <= 8'hff;
            ptr       <= 8'h00;
            left      <= 7'h00;
            drive_low <= 1'b0;
            scl_d     <= 1'b1;
            sda_d     <= 1'b1;
            wr_en     <= 1'b0;
            wr_addr   <= 8'h00;
            wr_data   <= 8'h00;
        end
        else
        begin
            scl_d <= scl_f;
            sda_d <= sda_f;
            wr_en <= 1'b0;
            if (!serial_on || stop_cond)
            begin
                state     <= S_IDLE;
                drive_low <= 1'b0;
            end
            else if (start_cond)
            begin
                state     <= S_ADDR;
                bitcnt    <= 4'h0;
                drive_low <= 1'b0;
            end
            else if (scl_rise)
            begin
                case (state)
                    S_ADDR, S_CMD, S_WDATA:
                    begin
                        shift  <= {shift[6:0], sda_f};
                        bitcnt <= bitcnt + 4'h1;
                    end
                    S_RDATA:
                        bitcnt <= bitcnt + 4'h1;
                    S_RACK:
                        state <= sda_f ? S_IDLE : S_NEXT;
                    default:
                        state <= state;
                endcase
            end
            else if (scl_fall)
            begin
                case (state)
                    S_ADDR:
                        if (bitcnt == 4'h8)
                        begin
                            bitcnt    <= 4'h0;
                            state     <= addr_hit ? S_ACK_A : S_IDLE;
                            drive_low <= addr_hit;
                            left      <= count_store[7:1];
                        end
                    S_ACK_A:
                        if (shift[0])
                        begin
                            state <= S_RDATA;
                            if (left != 7'h00)
                            begin
                                tx        <= rd_data;
                                drive_low <= ~rd_data[7];
                                left      <= left - 7'h01;
                                ptr       <= ptr + 8'h01;
                            end
                            else
                            begin
                                tx        <= 8'hff;
                                drive_low <= 1'b0;
                            end
                        end
                        else
                        begin
                            state     <= S_CMD;
                            drive_low <= 1'b0;
                        end
                    S_CMD:
                        if (bitcnt == 4'h8)
                        begin
                            bitcnt    <= 4'h0;
                            ptr       <= shift;
                            state     <= S_ACK_C;
                            drive_low <= 1'b1;
                        end
                    S_WDATA:
                        if (bitcnt == 4'h8)
                        begin
                            bitcnt    <= 4'h0;
                            wr_en     <= 1'b1;
                            wr_addr   <= ptr;
                            wr_data   <= shift;
                            ptr       <= ptr + 8'h01;
                            state     <= S_ACK_W;
                            drive_low <= 1'b1;
                        end
                    S_ACK_C, S_ACK_W:
                    begin
                        state     <= S_WDATA;
                        drive_low <= 1'b0;
                    end
                    S_RDATA:
                        if (bitcnt == 4'h8)
                        begin
                            bitcnt    <= 4'h0;
                            state     <= S_RACK;
                            drive_low <= 1'b0;
                        end
                        else
                            drive_low <= ~tx[3'h7 - bitcnt[2:0]];
                    S_NEXT:
                    begin
                        state <= S_RDATA;
                        if (left != 7'h00)
                        begin
                            tx        <= rd_data;
                            drive_low <= ~rd_data[7];
                            left      <= left - 7'h01;
                            ptr       <= ptr + 8'h01;
                        end
                        else
                        begin
                            tx        <= 8'hff;
                            drive_low <= 1'b0;
                        end
                    end
                    default:
                        drive_low <= 1'b0;
                endcase
            end
        end
    end

    // Register file, loaded from the stored copy after reset
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            boot        <= 1'b1;
            dev_ctrl    <= `RST_DEV_CTRL;
            out1_ctrl   <= `RST_OUT1_CTRL;
            div_low     <= `RST_DIV_LOW;
            state_sel   <= `RST_STATE_SEL;
            xtal_cap    <= `RST_XTAL_CAP;
            count_store <= `RST_COUNT_STORE;
        end
        else if (boot)
        begin
            boot        <= 1'b0;
            dev_ctrl    <= stored[7:0];
            out1_ctrl   <= stored[15:8];
            div_low     <= stored[23:16];
            state_sel   <= stored[31:24];
            xtal_cap    <= stored[39:32];
            count_store <= stored[47:40];
        end
        else if (wr_en && !busy)
        begin
            // Writes during a store are dropped; locked writes still act
            if (wr_addr == `OFS_DEV_CTRL)
                dev_ctrl <= wr_data & `MASK_DEV_CTRL;
            else if (wr_addr == `OFS_OUT1_CTRL)
                out1_ctrl <= wr_data;
            else if (wr_addr == `OFS_DIV_LOW)
                div_low <= wr_data;
            else if (wr_addr == `OFS_STATE_SEL)
                state_sel <= wr_data;
            else if (wr_addr == `OFS_XTAL_CAP)
                xtal_cap <= wr_data & `MASK_XTAL_CAP;
            else if (wr_addr == `OFS_COUNT_STORE)
                count_store <= wr_data;
        end
    end

    // Decoded device controls
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            out1_power_down    <= 1'b0;
            out1_tristate      <= 1'b1;
            out1_drive_low     <= 1'b0;
            out1_enable        <= 1'b0;
            out1_divider       <= 10'h001;
            out1_divider_reset <= 1'b0;
            out1_source_pll    <= 1'b1;
            xtal_load_pf       <= 5'h0a;
            input_clock_select <= 2'h0;
            slave_address_low  <= 2'h1;
            serial_pins_active <= 1'b1;
        end
        else
        begin
            out1_power_down    <= (state_now == `STATE_PWDN) | dev_ctrl[`BIT_PWDN];
            out1_tristate      <= (state_now == `STATE_PWDN) | (state_now == `STATE_TRI)
                                  | dev_ctrl[`BIT_PWDN];
            out1_drive_low     <= (state_now == `STATE_LOW) & ~dev_ctrl[`BIT_PWDN];
            out1_enable        <= (state_now == `STATE_ON) & ~dev_ctrl[`BIT_PWDN];
            out1_divider       <= {out1_ctrl[1:0], div_low};
            out1_divider_reset <= ({out1_ctrl[1:0], div_low} == 10'h000);
            out1_source_pll    <= out1_ctrl[`BIT_SRC_PLL];
            xtal_load_pf       <= (xtal_cap[7:3] > `CAP_MAX_PF) ? `CAP_MAX_PF
                                  : xtal_cap[7:3];
            input_clock_select <= dev_ctrl[3:2];
            slave_address_low  <= grounded ? 2'h0 : dev_ctrl[1:0];
            serial_pins_active <= serial_on;
        end
    end
endmodule // clock_config_bank
`default_nettype wire

// *** serial_host_model.sv ***
/*
 * Two-wire bus host model: start, stop and byte transfers, bit by bit.
 * Assumes the bench resolves the open-drain data line with a pull-up.
 */
`timescale 1ns/100ps
`default_nettype none
module serial_host_model #(
    parameter int Q = 6
)(
    // Clock
    input  wire logic clk,
    // Bus lines
    input  wire logic sda,
    output var  logic scl,
    output var  logic sda_low
);
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    task automatic tick();
        repeat (Q) @(negedge clk);
    endtask

    // Data changes only while the clock is low
    task automatic bit_io(input logic b, output logic r);
        sda_low = ~b;
        tick();
        scl = 1'b1;
        tick();
        r = sda;
        tick();
        scl = 1'b0;
        tick();
    endtask

    task automatic start();
        sda_low = 1'b0;
        tick();
        scl = 1'b1;
        tick();
        sda_low = 1'b1;
        tick();
        scl = 1'b0;
        tick();
    endtask

    task automatic stop();
        sda_low = 1'b1;
        tick();
        scl = 1'b1;
        tick();
        sda_low = 1'b0;
        tick();
    endtask

    task automatic byte_out(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask

    task automatic byte_in(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, d[i]);
        bit_io(last, r);
    endtask
endmodule // serial_host_model
`default_nettype wire

// *** clock_config_bank_assertions.sv ***
/*
 * Port-level checker of the clock configuration bank.
 * Assumes binding to every instance of the bank.
 */
`timescale 1ns/100ps
`default_nettype none
module clock_config_bank_checker #(
    parameter int STORE_CYCLE = 1000
)(
    input wire logic       clk,
    input wire logic       nrst,
    input wire logic       scl_pin,
    input wire logic       sda_pin_oe_n,
    input wire logic       output_supply,
    input wire logic       out1_power_down,
    input wire logic       out1_tristate,
    input wire logic       out1_drive_low,
    input wire logic       out1_enable,
    input wire logic [9:0] out1_divider,
    input wire logic       out1_divider_reset,
    input wire logic [4:0] xtal_load_pf,
    input wire logic [1:0] slave_address_low,
    input wire logic       nvm_store_in_progress,
    input wire logic       serial_pins_active
);
    int busy_len;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // Length of the running store
    always_ff @(posedge clk or negedge nrst)
        if (!nrst)
            busy_len <= 0;
        else
            busy_len <= nvm_store_in_progress ? busy_len + 1 : 0;

    a_div_zero_reset:
        assert property ($stable(out1_divider) |-> out1_divider_reset == (out1_divider == 10'h0))
        else $error("divider reset flag wrong");
    a_cap_saturate:
        assert property (xtal_load_pf <= 5'h14)
        else $error("load capacitance above twenty");
    a_state_exclusive:
        assert property ($onehot0({out1_power_down, out1_drive_low, out1_enable})
            && !(out1_enable && out1_tristate))
        else $error("output one states overlap");
    a_store_length:
        assert property ($fell(nvm_store_in_progress) |-> busy_len == STORE_CYCLE)
        else $error("store length wrong");
    a_store_bounded:
        assert property (busy_len <= STORE_CYCLE)
        else $error("store runs too long");
    a_grounded_addr:
        assert property (!output_supply [*8] |-> slave_address_low == 2'b00 && serial_pins_active)
        else $error("grounded supply not forcing serial");
    a_pin_fn_stored:
        assert property ((!nvm_store_in_progress && output_supply) [*8]
            |-> $stable(serial_pins_active))
        else $error("pin function changed outside a store");
    a_sda_scl_low:
        assert property ($changed(sda_pin_oe_n) |-> !scl_pin)
        else $error("data line changed while clock high");
endmodule // clock_config_bank_checker

bind clock_config_bank clock_config_bank_checker #(.STORE_CYCLE(STORE_CYCLE)) bank_chk (
    .clk(clk), .nrst(nrst), .scl_pin(scl_pin), .sda_pin_oe_n(sda_pin_oe_n),
    .output_supply(output_supply), .out1_power_down(out1_power_down),
    .out1_tristate(out1_tristate), .out1_drive_low(out1_drive_low),
    .out1_enable(out1_enable), .out1_divider(out1_divider),
    .out1_divider_reset(out1_divider_reset), .xtal_load_pf(xtal_load_pf),
    .slave_address_low(slave_address_low), .nvm_store_in_progress(nvm_store_in_progress),
    .serial_pins_active(serial_pins_active));
`default_nettype wire

// *** test_clock_config_bank.sv ***
/*
 * Testbench of the configuration bank: register traffic on the serial bus.
 * Assumes the host model and the checker are compiled first.
 */
`timescale 1ns/100ps
`default_nettype none
module test_clock_config_bank;
    localparam int STORE = 3000;
    logic            clk, nrst, supply, a, sel0;
    logic [6:0]      dev;
    logic [63:0]     q;
    logic [4:0]      caps [4] = '{5'h00, 5'h13, 5'h14, 5'h1f};
    int              fails, compares;
    wire logic       scl, sda, host_low, sda_out, oe_n, pd, tri_st, drv_low, en;
    wire logic       div_rst, src, busy, serial;
    wire logic [9:0] div;
    wire logic [4:0] pf;
    wire logic [1:0] ics, addr_lo;

    assign sda = ~(host_low | ~oe_n);
    always #5 clk = ~clk;

    clock_config_bank #(.STORE_CYCLE(STORE)) dut (
        .clk(clk), .nrst(nrst), .ctrl_select_0(sel0), .scl_pin(scl), .sda_pin_in(sda),
        .sda_pin_out(sda_out), .sda_pin_oe_n(oe_n), .output_supply(supply),
        .out1_power_down(pd), .out1_tristate(tri_st), .out1_drive_low(drv_low),
        .out1_enable(en), .out1_divider(div), .out1_divider_reset(div_rst),
        .out1_source_pll(src), .xtal_load_pf(pf), .input_clock_select(ics),
        .slave_address_low(addr_lo), .nvm_store_in_progress(busy), .serial_pins_active(serial));
    serial_host_model host (.clk(clk), .sda(sda), .scl(scl), .sda_low(host_low));

    task automatic cmp_pin(input logic [9:0] got, input logic [9:0] exp);
        compares++;
        if (got !== exp)
        begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
        cmp_pin({2'b00, got}, {2'b00, exp});
    endtask
    task automatic wr(input logic [7:0] ofs, input logic [15:0] d, input int n);
        host.start();
        host.byte_out({dev, 1'b0}, a);
        cmp_pin(10'(a), 10'h1);
        host.byte_out(ofs, a);
        for (int i = n - 1; i >= 0; i--)
            host.byte_out(d[8*i +: 8], a);
        host.stop();
        repeat (5) @(negedge clk);
    endtask
    task automatic rd(input logic [7:0] ofs, input int n);
        host.start();
        host.byte_out({dev, 1'b0}, a);
        host.byte_out(ofs, a);
        host.stop();
        host.start();
        host.byte_out({dev, 1'b1}, a);
        for (int i = 0; i < n; i++)
            host.byte_in(i == n - 1, q[8*(n-1-i) +: 8]);
        host.stop();
    endtask
    task automatic wait_idle();
        for (int k = 0; k < STORE + 100 && busy !== 1'b0; k++)
            @(negedge clk);
        cmp_pin(10'(busy), 10'h0);
    endtask
    task automatic close_out();
        $display("Compares %0d, fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial
    begin
        repeat (90000) @(posedge clk);
        fails++;
        close_out();
    end

    initial
    begin
        clk = 1'b0;
        nrst = 1'b0;
        supply = 1'b1;
        sel0 = 1'b1;
        dev = 7'h31;
        fails = 0;
        compares = 0;
        repeat (2) @(negedge clk);
        nrst = 1'b1;
        repeat (8) @(negedge clk);
        // Defaults, then one unmapped offset
        rd(8'h00, 8);
        cmp_reg(q[55:48], 8'h01);
        cmp_reg(q[47:40], 8'hb4);
        cmp_reg(q[39:32], 8'h01);
        cmp_reg(q[31:24], 8'h02);
        cmp_reg(q[23:16], 8'h50);
        cmp_reg(q[15:8], 8'h40);
        cmp_reg(q[7:0], 8'h00);
        cmp_pin({3'h0, en, pf, src}, {3'h0, 1'b1, 5'h0a, 1'b1});
        cmp_pin(10'(addr_lo), 10'h1);
        // Count of three stops byte four
        wr(8'h06, 8'h06, 1);
        rd(8'h03, 4);
        cmp_reg(q[7:0], 8'hff);
        cmp_reg(q[31:24], 8'h01);
        wr(8'h06, 8'h40, 1);
        // Every state code through the first definition
        wr(8'h04, 8'h00, 1);
        for (int c = 0; c < 4; c++)
        begin
            wr(8'h02, {4'hb, c[1:0], 2'b00}, 1);
            cmp_pin(10'({pd, tri_st & (c != 0), drv_low, en}), 10'(4'h8 >> c));
        end
        wr(8'h04, 8'hff, 1);
        cmp_pin(10'(en), 10'h1);
        wr(8'h02, 16'hb3ff, 2);
        cmp_pin(div, 10'h3ff);
        wr(8'h02, 16'hb000, 2);
        cmp_pin({div_rst, div[8:0]}, 10'h200);
        for (int k = 0; k < 4; k++)
        begin
            wr(8'h05, {caps[k], 3'b000}, 1);
            cmp_pin(10'(pf), 10'(caps[k] > 5'h14 ? 5'h14 : caps[k]));
        end
        // Store: reads served, writes dropped
        wr(8'h06, 8'h41, 1);
        cmp_pin(10'(busy), 10'h1);
        rd(8'h01, 1);
        cmp_reg(q[7:0], 8'h41);
        wr(8'h03, 8'h77, 1);
        wait_idle();
        rd(8'h03, 1);
        cmp_reg(q[7:0], 8'h00);
        wr(8'h06, 8'h41, 1);
        cmp_pin(10'(busy), 10'h0);
        // Pin function acts only once stored
        wr(8'h06, 8'h40, 1);
        wr(8'h02, 8'hf0, 1);
        cmp_pin(10'(serial), 10'h1);
        wr(8'h06, 8'h41, 1);
        wait_idle();
        repeat (10) @(negedge clk);
        cmp_pin(10'(serial), 10'h0);
        supply = 1'b0;
        repeat (20) @(negedge clk);
        cmp_pin({serial, 7'h0, addr_lo}, 10'h200);
        dev = 7'h30;
        // Volatile lock stores once, then locks
        wr(8'h06, 8'h40, 1);
        wr(8'h01, 8'h3c, 1);
        cmp_pin({4'h0, sda_out, ics, pd, tri_st, en}, 10'h01e);
        wr(8'h06, 8'h41, 1);
        cmp_pin(10'(busy), 10'h1);
        wait_idle();
        wr(8'h06, 8'h40, 1);
        wr(8'h06, 8'h41, 1);
        cmp_pin(10'(busy), 10'h0);
        wr(8'h03, 8'h2a, 1);
        cmp_pin(div, 10'h02a);
        close_out();
    end
endmodule // test_clock_config_bank
`default_nettype wire
